// *** logic/sbc_mode_pkg.sv ***
// constants, register map and mode encoding of the lin sbc mode controller
// assumes a 40 mhz clock; long counts are overridable on the top module
package sbc_mode_pkg;

    // =====================================================================
    // clock
    localparam int CLK_PERIOD_NS = 25;

    // =====================================================================
    // times in their own units, cycles derived (least times round up)
    localparam int T_RES_MS = 4;
    localparam int RES_CYC = (T_RES_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_IGN_DB_US = 160;
    localparam int IGN_DB_CYC = (T_IGN_DB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest time, rounds down
    localparam int T_SEL_WIN_NS = 3200;
    localparam int SEL_WIN_CYC = T_SEL_WIN_NS / CLK_PERIOD_NS;
    localparam int T_BUS_FILT_US = 30;
    localparam int BUS_FILT_CYC = (T_BUS_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WAKE_FILT_US = 30;
    localparam int WAKE_FILT_CYC = (T_WAKE_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WD_MS = 20;
    localparam int WD_CYC = (T_WD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // =====================================================================
    // register map
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h04;
    localparam int CTRL_BUS_WAKE_BIT = 0;
    localparam int CTRL_PIN_WAKE_BIT = 1;
    localparam int CTRL_IGN_WAKE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h7;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_WAKE_REQ_BIT = 8;
    localparam int STAT_WAKE_LOCAL_BIT = 9;
    localparam int STAT_RES_LOW_BIT = 10;

    // =====================================================================
    // synchronised pin indices
    localparam int PIN_EN = 0;
    localparam int PIN_TXD = 1;
    localparam int PIN_KICK = 2;
    localparam int PIN_WD_OFF = 3;
    localparam int PIN_BUS = 4;
    localparam int PIN_WAKE = 5;
    localparam int PIN_IGN = 6;
    localparam int PIN_VS_OK = 7;
    localparam int PIN_VCC_OK = 8;
    localparam int PIN_NRES = 9;
    localparam int PIN_N = 10;
    localparam logic [PIN_N-1:0] SYNC_RESET = 10'h2bf;

    // =====================================================================
    // operating modes, one-hot
    typedef enum logic [5:0] {
        ST_UNPOWERED = 6'h01,
        ST_FAILSAFE = 6'h02,
        ST_NORMAL = 6'h04,
        ST_SELECT = 6'h08,
        ST_SILENT = 6'h10,
        ST_SLEEP = 6'h20
    } mode_t;

endpackage

// *** logic/level_hold_filter.sv ***
// hold filter: pulses once when a level has stood for a terminal count
// assumes its input is already synchronised to clk
`timescale 1ns/1ps
module level_hold_filter
    import sbc_mode_pkg::*;
#(
    parameter int TERM = 100,
    parameter bit ACTIVE_HIGH = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level in, results out
    input wire logic level,
    output logic hit,
    output logic held
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic hit_reg;
    logic hit_next;
    logic active;

    // =====================================================================
    // counter saturates, so a new edge is needed for a second hit
    assign active = (level == ACTIVE_HIGH);
    always_comb
    begin
        cnt_next = '0;
        hit_next = 1'b0;
        if (active)
        begin
            cnt_next = (cnt_reg == CNT_W'(TERM)) ? cnt_reg : cnt_reg + 1'b1;
            hit_next = (cnt_reg == CNT_W'(TERM - 1));
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end

    assign hit = hit_reg;
    assign held = (cnt_reg == CNT_W'(TERM));

endmodule // level_hold_filter

// *** logic/lin_sbc_mode_controller.sv ***
// operating-mode controller of a lin transceiver system basis chip
// assumes pins arrive asynchronous and are synchronised here; 40 mhz clk
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - enable high gives normal, both paths on
// - enable falls, transmit high: silent, regulator on
// - enable falls, transmit low: sleep, regulator off
// - sleep holds reset and receive low
// - sleep still taken if transmit falls late
// - sleep or silent entry ignores wake pins
// - long bus dominant then release wakes
// - remote wake restores regulator, receive low
// - silent plus enable high goes normal
// - sleep plus enable: fail-safe, then normal
// - reset low forces fail-safe from normal, select or silent
// - silent undervoltage forces reset and fail-safe
// - power-up enters fail-safe, regulator on
// - power-up holds reset low four milliseconds
// - fail-safe waits for enable, then normal
// - battery loss in low power restarts fail-safe
// - fail-safe drives transmit pin as source
// - no mode change during power-up reset
// - supply switch on only normal, fail-safe
// - reset low on undervoltage or watchdog
// - watchdog off while disable pin high
// - ignition rise debounced before local wake
// - long low on wake pin wakes
// - transmit weak high remote, strong low local
// - wake flags clear on reaching normal
module lin_sbc_mode_controller
    import sbc_mode_pkg::*;
#(
    parameter int RES_TERM = RES_CYC,
    parameter int IGN_TERM = IGN_DB_CYC,
    parameter int WD_TERM = WD_CYC,
    parameter int BUS_TERM = BUS_FILT_CYC,
    parameter int WAKE_TERM = WAKE_FILT_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host pins
    input wire logic en,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    output logic txd_strong,
    input wire logic watchdog_kick_n,
    input wire logic wd_off,
    output logic rxd_out,
    // reset pin, open drain
    input wire logic nres_in,
    output logic nres_out,
    output logic nres_oe,
    // bus and wake pins
    input wire logic bus_rx,
    output logic bus_drive_dom,
    output logic bus_term_on,
    input wire logic wake_n,
    input wire logic ignition_wake_input,
    // supplies
    input wire logic vs_ok,
    input wire logic vcc_ok,
    output logic regulator_on,
    output logic ext_supply_switch,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sbc_mode_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import sbc_mode_pkg::*;

    // =====================================================================
    // pin synchronisers
    logic [PIN_N-1:0] raw;
    logic [PIN_N-1:0] s1_reg;
    logic [PIN_N-1:0] s2_reg;
    logic [PIN_N-1:0] s3_reg;
    assign raw = {nres_in, vcc_ok, vs_ok, ignition_wake_input, wake_n, bus_rx,
                  wd_off, watchdog_kick_n, txd_in, en};

    // two flops per pin, third for edges
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    s1_reg[gi] <= SYNC_RESET[gi];
                    s2_reg[gi] <= SYNC_RESET[gi];
                    s3_reg[gi] <= SYNC_RESET[gi];
                end
                else
                begin
                    s1_reg[gi] <= raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                end
            end
        end
    endgenerate

    logic en_s, txd_s, bus_s, vs_s, uv, nres_s, en_fall, kick_fall, wd_off_s;
    assign en_s = s2_reg[PIN_EN];
    assign txd_s = s2_reg[PIN_TXD];
    assign bus_s = s2_reg[PIN_BUS];
    assign vs_s = s2_reg[PIN_VS_OK];
    assign uv = !s2_reg[PIN_VCC_OK];
    assign nres_s = s2_reg[PIN_NRES];
    assign wd_off_s = s2_reg[PIN_WD_OFF];
    assign en_fall = s3_reg[PIN_EN] && !en_s;
    assign kick_fall = s3_reg[PIN_KICK] && !s2_reg[PIN_KICK];

    // =====================================================================
    // wake filters
    logic bus_held, pin_hit, ign_hit;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic remote_wake, local_wake;

    level_hold_filter #(.TERM(BUS_TERM), .ACTIVE_HIGH(1'b0)) u_bus_filt (
        .clk(clk), .rst_b(rst_b), .level(bus_s), .hit(), .held(bus_held));
    level_hold_filter #(.TERM(WAKE_TERM), .ACTIVE_HIGH(1'b0)) u_pin_filt (
        .clk(clk), .rst_b(rst_b), .level(s2_reg[PIN_WAKE]), .hit(pin_hit), .held());
    level_hold_filter #(.TERM(IGN_TERM), .ACTIVE_HIGH(1'b1)) u_ign_filt (
        .clk(clk), .rst_b(rst_b), .level(s2_reg[PIN_IGN]), .hit(ign_hit), .held());

    assign remote_wake = bus_held && bus_s && ctrl_reg[CTRL_BUS_WAKE_BIT];
    assign local_wake = (pin_hit && ctrl_reg[CTRL_PIN_WAKE_BIT])
                        || (ign_hit && ctrl_reg[CTRL_IGN_WAKE_BIT]);

    // =====================================================================
    // mode sequencer
    mode_t state_reg, state_next;
    logic [7:0] sel_reg, sel_next;
    logic [CNT_W-1:0] res_reg, res_next;
    logic [CNT_W-1:0] wd_reg, wd_next;
    logic wake_req_reg, wake_req_next;
    logic wake_local_reg, wake_local_next;
    logic res_low, wd_run, wd_fail, reset_evt, any_wake, low_power;

    assign low_power = (state_reg == ST_SILENT) || (state_reg == ST_SLEEP);
    // undervoltage, timer or watchdog hold reset
    assign res_low = uv || (res_reg != '0) || (state_reg == ST_SLEEP)
                     || (state_reg == ST_UNPOWERED);
    // watchdog runs only with disable pin low
    assign wd_run = !wd_off_s && !res_low
                    && ((state_reg == ST_NORMAL) || (state_reg == ST_FAILSAFE));
    assign wd_fail = wd_run && !kick_fall && (wd_reg == CNT_W'(WD_TERM - 1));
    assign reset_evt = !nres_s || uv || wd_fail;
    assign any_wake = remote_wake || local_wake;

    always_comb
    begin
        state_next = state_reg;
        sel_next = sel_reg;
        wake_req_next = wake_req_reg;
        wake_local_next = wake_local_reg;
        // reset time reloads while any cause stands
        if (uv || wd_fail || state_reg == ST_UNPOWERED)
            res_next = CNT_W'(RES_TERM);
        else
            res_next = (res_reg != '0) ? res_reg - 1'b1 : res_reg;
        wd_next = (wd_run && !kick_fall && !wd_fail) ? wd_reg + 1'b1 : '0;
        case (state_reg)
            ST_UNPOWERED:
            begin
                if (vs_s)
                    state_next = ST_FAILSAFE;
            end
            ST_FAILSAFE:
            begin
                if (en_s && !res_low && nres_s)
                    state_next = ST_NORMAL;
            end
            ST_NORMAL:
            begin
                if (reset_evt)
                    state_next = ST_FAILSAFE;
                // entry ignores bus and wake levels
                else if (en_fall && !txd_s)
                    state_next = ST_SLEEP;
                else if (en_fall)
                begin
                    state_next = ST_SELECT;
                    sel_next = '0;
                end
            end
            ST_SELECT:
            begin
                sel_next = sel_reg + 1'b1;
                if (reset_evt)
                    state_next = ST_FAILSAFE;
                // late transmit fall still means sleep
                else if (!txd_s)
                    state_next = ST_SLEEP;
                else if (en_s)
                    state_next = ST_NORMAL;
                else if (sel_reg == 8'(SEL_WIN_CYC - 1))
                    state_next = ST_SILENT;
            end
            ST_SILENT:
            begin
                if (any_wake || reset_evt)
                    state_next = ST_FAILSAFE;
                else if (en_s)
                    state_next = ST_NORMAL;
            end
            ST_SLEEP:
            begin
                // enable or wake restarts via fail-safe
                if (any_wake || en_s)
                    state_next = ST_FAILSAFE;
            end
            default:
                state_next = ST_FAILSAFE;
        endcase
        if (!vs_s)
            state_next = ST_UNPOWERED;
        if (low_power && any_wake)
        begin
            wake_req_next = 1'b1;
            wake_local_next = local_wake;
        end
        // cleared on the edge that enters normal, so status never shows both
        else if (state_next == ST_NORMAL)
        begin
            wake_req_next = 1'b0;
            wake_local_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_UNPOWERED;
            sel_reg <= '0;
            res_reg <= '0;
            wd_reg <= '0;
            wake_req_reg <= 1'b0;
            wake_local_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            res_reg <= res_next;
            wd_reg <= wd_next;
            wake_req_reg <= wake_req_next;
            wake_local_reg <= wake_local_next;
        end
    end

    // =====================================================================
    // pin outputs, all registered one cycle behind the mode
    logic rxd_next, txd_oe_next, txd_out_next, txd_strong_next, dom_next, term_next;
    logic reg_on_next, ext_next;
    always_comb
    begin
        dom_next = (state_reg == ST_NORMAL) && !txd_s;
        rxd_next = 1'b1;
        if (state_reg == ST_NORMAL)
            rxd_next = bus_s;
        else if (state_reg == ST_SLEEP || state_reg == ST_UNPOWERED)
            rxd_next = 1'b0;
        else if (state_reg == ST_FAILSAFE)
            rxd_next = !wake_req_reg;
        // transmit pin reports the last source
        // strong low for local, weak high for remote
        txd_oe_next = (state_reg == ST_FAILSAFE);
        txd_out_next = !wake_local_reg;
        txd_strong_next = wake_local_reg;
        // only a weak pull-up until a pre-wake low appears
        term_next = !(low_power || state_reg == ST_UNPOWERED) || !bus_s;
        reg_on_next = !(state_reg == ST_SLEEP || state_reg == ST_UNPOWERED);
        // switch on in normal and fail-safe only
        ext_next = (state_reg == ST_NORMAL || state_reg == ST_FAILSAFE) && !uv;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_out <= 1'b0;
            txd_oe <= 1'b0;
            txd_out <= 1'b1;
            txd_strong <= 1'b0;
            bus_drive_dom <= 1'b0;
            bus_term_on <= 1'b0;
            regulator_on <= 1'b0;
            ext_supply_switch <= 1'b0;
            nres_out <= 1'b0;
            nres_oe <= 1'b1;
        end
        else
        begin
            rxd_out <= rxd_next;
            txd_oe <= txd_oe_next;
            txd_out <= txd_out_next;
            txd_strong <= txd_strong_next;
            bus_drive_dom <= dom_next;
            bus_term_on <= term_next;
            regulator_on <= reg_on_next;
            ext_supply_switch <= ext_next;
            nres_out <= 1'b0;
            nres_oe <= res_low;
        end
    end

    // =====================================================================
    // wishbone slave, one wait state; unmapped reads return zero
    logic ack_next;
    logic [31:0] dat_next;
    always_comb
    begin
        ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;
        ctrl_next = ctrl_reg;
        dat_next = '0;
        if (ack_next && wb_adr_i == ADR_CTRL)
            dat_next[2:0] = ctrl_reg;
        if (ack_next && wb_adr_i == ADR_STATUS)
        begin
            dat_next[STAT_MODE_LSB +: 6] = state_reg;
            dat_next[STAT_WAKE_REQ_BIT] = wake_req_reg;
            dat_next[STAT_WAKE_LOCAL_BIT] = wake_local_reg;
            dat_next[STAT_RES_LOW_BIT] = res_low;
        end
        if (ack_next && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
            ctrl_next = wb_dat_i[2:0];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            wb_ack_o <= ack_next;
            wb_dat_o <= dat_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // =====================================================================
    // checks
    localparam int A_SEL_MAX = SEL_WIN_CYC + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_quiet_fall;
        (state_reg == ST_NORMAL) && en_fall && txd_s && !reset_evt && vs_s;
    endsequence
    // window length counted by a bounded delay, not an open repetition
    sequence s_held_quiet;
        (txd_s && !en_s && !reset_evt && vs_s && !any_wake) throughout
            ##[A_SEL_MAX:A_SEL_MAX] 1'b1;
    endsequence

    a_silent_entry: assert property (
        s_quiet_fall ##1 s_held_quiet |-> (state_reg == ST_SILENT))
        else $error("silent not entered after select window");
    a_sleep_entry: assert property (
        (state_reg == ST_NORMAL) && en_fall && !txd_s && !reset_evt && vs_s
            |=> (state_reg == ST_SLEEP) ##1 !regulator_on)
        else $error("sleep entry or regulator off missing");
    a_sleep_pins: assert property (
        (state_reg == ST_SLEEP) |=> (!rxd_out && nres_oe))
        else $error("sleep must hold receive and reset low");
    a_remote_wake: assert property (
        low_power && remote_wake && vs_s
            |=> (state_reg == ST_FAILSAFE) ##1 (!rxd_out && regulator_on))
        else $error("remote wake not reported");
    a_mode_lock: assert property (
        (state_reg == ST_FAILSAFE) && res_low |=> (state_reg != ST_NORMAL))
        else $error("mode changed while reset held");
    a_powerup_hold: assert property (
        (state_reg == ST_UNPOWERED) && vs_s |=> nres_oe [*8])
        else $error("reset released too early after power-up");
    a_ext_switch: assert property (
        low_power || uv |=> !ext_supply_switch)
        else $error("supply switch on in low power or undervoltage");
    a_wd_off: assert property (
        wd_off_s |-> !wd_fail ##1 (wd_reg == '0))
        else $error("watchdog ran while disabled");
    a_wake_clear: assert property (
        (state_reg == ST_NORMAL) |-> !wake_req_reg && !wake_local_reg)
        else $error("wake flags kept in normal");

endmodule // lin_sbc_mode_controller

// *** sim/host_model.sv ***
// host microcontroller model: enable, transmit and watchdog kick pins
// assumes one clk domain; the bench commands the pin levels
`timescale 1ns/1ps
module host_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // commands from the bench
    input wire logic en_cmd,
    input wire logic txd_cmd,
    input wire logic kick_on,
    // host pins
    output logic en,
    output logic txd_drv,
    output logic watchdog_kick_n
);
    // =====================================================================
    // pin drivers
    logic [5:0] kick_reg;
    // enable and transmit fall on one edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en <= 1'b0;
            txd_drv <= 1'b1;
            kick_reg <= 6'h00;
            watchdog_kick_n <= 1'b1;
        end
        else
        begin
            en <= en_cmd;
            txd_drv <= txd_cmd;
            kick_reg <= kick_reg + 6'h01;
            // short low pulse every 64 cycles, well inside the timeout
            watchdog_kick_n <= !(kick_on && kick_reg[5:2] == 4'h0);
        end
    end
endmodule // host_model

// *** sim/tb.sv ***
// self-checking bench for the lin sbc mode controller
// assumes small terminal counts; host model drives en, txd and kick
`timescale 1ns/1ps
module tb;
    import sbc_mode_pkg::*;
    // =====================================================================
    // signals
    logic clk, rst_b, en_cmd, txd_cmd, kick_on, en, txd_drv, kick_n;
    logic txd_out, txd_oe, txd_strong, wd_off, rxd_out, nres_oe, nres_o, dom, term;
    logic bus_rx, wake_n, ign, vs_ok, vcc_ok, reg_on, ext_sw, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, wb_rd, rdat, st;
    int error_cnt, n_tests, cyc_cnt;
    // strong pull-down of the device wins over the host
    wire txd_pin = (txd_oe && txd_strong) ? 1'b0 : txd_drv;

    host_model i_host (.clk(clk), .rst_b(rst_b), .en_cmd(en_cmd), .txd_cmd(txd_cmd),
        .kick_on(kick_on), .en(en), .txd_drv(txd_drv), .watchdog_kick_n(kick_n));

    lin_sbc_mode_controller #(.RES_TERM(40), .IGN_TERM(20), .WD_TERM(200),
        .BUS_TERM(10), .WAKE_TERM(10)) i_dut (.clk(clk), .rst_b(rst_b), .en(en),
        .txd_in(txd_pin), .txd_out(txd_out), .txd_oe(txd_oe), .txd_strong(txd_strong),
        .watchdog_kick_n(kick_n), .wd_off(wd_off), .rxd_out(rxd_out),
        .nres_in(!nres_oe), .nres_out(nres_o), .nres_oe(nres_oe), .bus_rx(bus_rx),
        .bus_drive_dom(dom), .bus_term_on(term), .wake_n(wake_n),
        .ignition_wake_input(ign), .vs_ok(vs_ok), .vcc_ok(vcc_ok),
        .regulator_on(reg_on), .ext_supply_switch(ext_sw), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_rd), .wb_ack_o(ack));

    // =====================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // the bench timeout is the only limit on the wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = wb_rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wait_mode(input logic [5:0] m);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, ADR_STATUS, 32'h0);
            n++;
        end
        while (rdat[5:0] !== m && n < 200);
        st = rdat;
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // =====================================================================
    // scenarios
    task automatic t_power();
        en_cmd <= 1'b1;
        vs_ok <= 1'b1;
        vcc_ok <= 1'b1;
        repeat (20) @(posedge clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        check(rdat[5:0], ST_FAILSAFE);
        check({reg_on, nres_oe, dom}, 3'h6);
        repeat (40) @(posedge clk);
        check(nres_oe, 1'b0);
        wait_mode(ST_NORMAL);
        check(st[5:0], ST_NORMAL);
        check({ext_sw, reg_on, term}, 3'h7);
        txd_cmd <= 1'b0;
        bus_rx <= 1'b0;
        repeat (6) @(posedge clk);
        check({dom, rxd_out}, 2'h2);
        txd_cmd <= 1'b1;
        bus_rx <= 1'b1;
        $display("test power done");
    endtask

    task automatic t_regs();
        wb(1'b0, ADR_CTRL, 32'h0);
        check(rdat, 32'h7);
        wb(1'b1, ADR_CTRL, 32'h6);
        wb(1'b0, ADR_CTRL, 32'h0);
        check(rdat, 32'h6);
        wb(1'b0, 8'h08, 32'h0);
        check(rdat, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h7);
        $display("test regs done");
    endtask

    task automatic t_silent();
        en_cmd <= 1'b0;
        wait_mode(ST_SILENT);
        check(st[5:0], ST_SILENT);
        check({reg_on, ext_sw, dom, term}, 4'h8);
        en_cmd <= 1'b1;
        wait_mode(ST_NORMAL);
        check(st[5:0], ST_NORMAL);
        $display("test silent done");
    endtask

    task automatic t_sleep();
        ign <= 1'b1;
        en_cmd <= 1'b0;
        txd_cmd <= 1'b0;
        wait_mode(ST_SLEEP);
        txd_cmd <= 1'b1;
        check(st[5:0], ST_SLEEP);
        check({reg_on, nres_oe, rxd_out, ext_sw, term}, 5'h08);
        ign <= 1'b0;
        bus_rx <= 1'b0;
        repeat (20) @(posedge clk);
        bus_rx <= 1'b1;
        wait_mode(ST_FAILSAFE);
        check(st[5:0], ST_FAILSAFE);
        check({rxd_out, reg_on, txd_oe, txd_out, txd_strong}, 5'h0e);
        en_cmd <= 1'b1;
        wait_mode(ST_NORMAL);
        check({st[9:8], st[5:0]}, {2'h0, ST_NORMAL});
        $display("test sleep done");
    endtask

    task automatic t_local(input logic use_ign);
        en_cmd <= 1'b0;
        wait_mode(ST_SILENT);
        ign <= use_ign;
        wake_n <= use_ign;
        repeat (30) @(posedge clk);
        wake_n <= 1'b1;
        wait_mode(ST_FAILSAFE);
        check(st[5:0], ST_FAILSAFE);
        check({st[9:8], txd_oe, txd_strong, txd_out}, 5'h1e);
        ign <= 1'b0;
        en_cmd <= 1'b1;
        wait_mode(ST_NORMAL);
        check(st[9:8], 2'h0);
        $display("test local done");
    endtask

    task automatic t_faults();
        en_cmd <= 1'b0;
        wait_mode(ST_SILENT);
        vcc_ok <= 1'b0;
        wait_mode(ST_FAILSAFE);
        check({st[5:0], nres_oe, ext_sw}, {ST_FAILSAFE, 2'h2});
        vcc_ok <= 1'b1;
        en_cmd <= 1'b1;
        wait_mode(ST_NORMAL);
        wd_off <= 1'b1;
        kick_on <= 1'b0;
        repeat (300) @(posedge clk);
        wait_mode(ST_NORMAL);
        check(st[5:0], ST_NORMAL);
        wd_off <= 1'b0;
        wait_mode(ST_FAILSAFE);
        check({st[5:0], nres_oe, nres_o}, {ST_FAILSAFE, 2'h2});
        kick_on <= 1'b1;
        wait_mode(ST_NORMAL);
        en_cmd <= 1'b0;
        txd_cmd <= 1'b0;
        wait_mode(ST_SLEEP);
        check(st[5:0], ST_SLEEP);
        vs_ok <= 1'b0;
        wait_mode(ST_UNPOWERED);
        check(st[5:0], ST_UNPOWERED);
        vs_ok <= 1'b1;
        wait_mode(ST_FAILSAFE);
        check(st[5:0], ST_FAILSAFE);
        $display("test faults done");
    endtask

    // =====================================================================
    // clock, timeout and main sequence
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 40000)
        begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end

    initial
    begin
        {rst_b, en_cmd, ign, vs_ok, vcc_ok, wd_off, cyc, stb, we} = 9'h0;
        {txd_cmd, kick_on, bus_rx, wake_n} = 4'hf;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_power();
        t_regs();
        t_silent();
        t_sleep();
        t_local(1'b0);
        t_local(1'b1);
        t_faults();
        conclude();
    end
endmodule // tb
